// >>> verilog/ifd_pkg.sv
// shared constants and types for the interlaced field readout block
package ifd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PIX_W = 10;
  localparam int OUT_W = 12;
  localparam int SUM_W = 13;
  localparam int AUX_W = 14;
  localparam int LINE_W = 12;
  localparam int GAIN_W = 8;
  localparam int GAIN_FRAC = 6;
  localparam int SHUT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 3 + LINE_W + OUT_W + AUX_W;

  // ----------------------------------------------------------------
  // field store geometry (plain defaults)
  // ----------------------------------------------------------------
  localparam int FL_AW = 3;
  localparam int COL_W = 4;
  localparam int MEM_DEPTH = 1 << (FL_AW + COL_W);
  localparam logic [SHUT_W-1:0] FIELD_LINES = 16'h0008;
  localparam logic [SHUT_W-1:0] MIN_FRAME_SHUTTER = FIELD_LINES + 16'h0001;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SHUTTER = 8'h04;
  localparam logic [ADDR_W-1:0] REG_GAIN0 = 8'h08;
  localparam logic [ADDR_W-1:0] GAIN_STRIDE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam int CTRL_ACT_LSB = 4;
  localparam int CTRL_COLOR_BIT = 8;
  localparam int STAT_LINE_LSB = 4;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 8'h40;
  localparam logic [SHUT_W-1:0] SHUTTER_RESET = 16'h0010;
  localparam int NUM_GAINS = 4;

  // ----------------------------------------------------------------
  // gain slots: field mode sums / frame mode channels
  // ----------------------------------------------------------------
  localparam logic [1:0] GI_CY_G = 2'h0;
  localparam logic [1:0] GI_MG_YE = 2'h1;
  localparam logic [1:0] GI_MG_CY = 2'h2;
  localparam logic [1:0] GI_G_YE = 2'h3;
  localparam logic [1:0] GI_CY = 2'h0;
  localparam logic [1:0] GI_YE = 2'h1;
  localparam logic [1:0] GI_MG = 2'h2;
  localparam logic [1:0] GI_G = 2'h3;
  localparam logic [1:0] GI_MONO = 2'h0;

  typedef enum logic [1:0] {
    IFD_MODE_FIELD = 2'h0,
    IFD_MODE_FRAME = 2'h1,
    IFD_MODE_PROG = 2'h2
  } ifd_mode_t;

  typedef enum logic [2:0] {
    ST_P0 = 3'b001,
    ST_P1 = 3'b010,
    ST_EMIT2 = 3'b100
  } ifd_state_t;

endpackage

// >>> verilog/ifd_gain.sv
// fixed-point gain multiplier for one pixel
`timescale 1ns/1ps
`default_nettype none
module ifd_gain (
  // operands
  input wire logic [ifd_pkg::PIX_W-1:0] pix,
  input wire logic [ifd_pkg::GAIN_W-1:0] gain,
  // result
  output logic [ifd_pkg::OUT_W-1:0] result
);
  logic [ifd_pkg::PIX_W+ifd_pkg::GAIN_W-1:0] prod;

  // full-scale input at the largest gain still fits, so no clamp is needed
  always_comb begin
    prod = pix * gain;
    result = prod[ifd_pkg::GAIN_FRAC +: ifd_pkg::OUT_W];
  end
endmodule
`default_nettype wire

// >>> verilog/ifd_skid.sv
// two-entry skid buffer, all outputs registered
`timescale 1ns/1ps
`default_nettype none
module ifd_skid #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic skid_valid;
  logic [W-1:0] skid_data;

  assign in_ready = !skid_valid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
      skid_valid <= 1'b0;
      skid_data <= '0;
    end else if (!out_valid || out_ready) begin
      if (skid_valid) begin
        out_data <= skid_data;
        out_valid <= 1'b1;
        skid_valid <= 1'b0;
      end else begin
        out_valid <= in_valid;
        if (in_valid) begin
          out_data <= in_data;
        end
      end
    end else if (in_valid && !skid_valid) begin
      skid_data <= in_data;
      skid_valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/ifd_readout.sv
// interlaced field readout: line mapping, gains, luma/chroma rebuild
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ifd_readout (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [ifd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ifd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ifd_pkg::DATA_W-1:0] reg_rdata,
  // camera strap
  input wire logic color_camera_pin,
  // sensor stream from the front end
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [ifd_pkg::PIX_W-1:0] in_data,
  input wire logic in_sof,
  input wire logic in_sol,
  input wire logic in_field,
  // image stream to the host link
  output logic out_valid,
  input wire logic out_ready,
  output logic [ifd_pkg::OUT_W-1:0] out_pix,
  output logic [ifd_pkg::AUX_W-1:0] out_aux,
  output logic [ifd_pkg::LINE_W-1:0] out_line,
  output logic out_field,
  output logic out_sof,
  output logic out_sol,
  // sensor timing
  output logic integration_active_out,
  output logic shutter_dump_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [ifd_pkg::LINE_W-1:0] line_pos(
    input logic [ifd_pkg::LINE_W-1:0] k,
    input logic shift
  );
    line_pos = {k[ifd_pkg::LINE_W-2:0], 1'b0} + {{(ifd_pkg::LINE_W-1){1'b0}}, 1'b1}
      + {{(ifd_pkg::LINE_W-1){1'b0}}, shift};
  endfunction

  function automatic logic is_gain_addr(
    input logic [ifd_pkg::ADDR_W-1:0] a,
    input int idx
  );
    is_gain_addr = (a == ifd_pkg::ADDR_W'(ifd_pkg::REG_GAIN0 + ifd_pkg::GAIN_STRIDE * idx));
  endfunction

  // ----------------------------------------------------------------
  // strap synchroniser
  // ----------------------------------------------------------------
  logic color_meta;
  logic color_camera;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      color_meta <= 1'b0;
      color_camera <= 1'b0;
    end else begin
      color_meta <= color_camera_pin;
      color_camera <= color_meta;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  ifd_pkg::ifd_mode_t mode_req;
  ifd_pkg::ifd_mode_t active_mode;
  logic [ifd_pkg::SHUT_W-1:0] shutter;
  logic [ifd_pkg::GAIN_W-1:0] gain [ifd_pkg::NUM_GAINS];
  logic [1:0] wr_mode;
  logic [ifd_pkg::SHUT_W-1:0] wr_shut;

  assign wr_mode = reg_wdata[1:0];
  assign wr_shut = reg_wdata[ifd_pkg::SHUT_W-1:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_req <= ifd_pkg::IFD_MODE_FIELD;
      shutter <= ifd_pkg::SHUTTER_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ifd_pkg::REG_CTRL) begin
        if (wr_mode == ifd_pkg::IFD_MODE_FIELD) begin
          mode_req <= ifd_pkg::IFD_MODE_FIELD;
        end else if (wr_mode == ifd_pkg::IFD_MODE_PROG) begin
          if (!color_camera) begin
            mode_req <= ifd_pkg::IFD_MODE_PROG;
          end
        end else if (wr_mode == ifd_pkg::IFD_MODE_FRAME) begin
          mode_req <= ifd_pkg::IFD_MODE_FRAME;
          // entering frame mode drags a short shutter up to the minimum
          if (shutter < ifd_pkg::MIN_FRAME_SHUTTER) begin
            shutter <= ifd_pkg::MIN_FRAME_SHUTTER;
          end
        end
      end else if (reg_addr == ifd_pkg::REG_SHUTTER) begin
        if (mode_req != ifd_pkg::IFD_MODE_FRAME || wr_shut >= ifd_pkg::MIN_FRAME_SHUTTER) begin
          shutter <= wr_shut;
        end
      end
    end
  end

  generate
    for (genvar gi = 0; gi < ifd_pkg::NUM_GAINS; gi++) begin : g_gain
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          gain[gi] <= ifd_pkg::GAIN_RESET;
        end else if (reg_wr && is_gain_addr(reg_addr, gi)) begin
          gain[gi] <= reg_wdata[ifd_pkg::GAIN_W-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sensor position tracking
  // ----------------------------------------------------------------
  ifd_pkg::ifd_state_t state;
  logic buf_ready;
  logic acc;
  logic [ifd_pkg::LINE_W-1:0] line_k;
  logic [ifd_pkg::COL_W-1:0] col;
  logic field;
  ifd_pkg::ifd_mode_t cur_mode;
  logic [ifd_pkg::LINE_W-1:0] cur_k;
  logic [ifd_pkg::COL_W-1:0] cur_col;
  logic cur_field;
  logic f_eff;
  logic [1:0] row_lo;
  logic [1:0] gidx;
  logic [ifd_pkg::LINE_W-1:0] cur_line;

  assign in_ready = (state == ifd_pkg::ST_P0) || (state == ifd_pkg::ST_P1 && buf_ready);
  assign acc = in_valid && in_ready;

  always_comb begin
    // a new frame starts with the first field; only then the mode may change
    cur_mode = (in_sof && !in_field) ? mode_req : active_mode;
    cur_k = in_sof ? '0 : (in_sol ? line_k + {{(ifd_pkg::LINE_W-1){1'b0}}, 1'b1} : line_k);
    cur_col = (in_sof || in_sol) ? '0 : col + {{(ifd_pkg::COL_W-1){1'b0}}, 1'b1};
    cur_field = in_sof ? in_field : field;
    // progressive emulation keeps the same pairing in both fields
    f_eff = cur_field && (cur_mode != ifd_pkg::IFD_MODE_PROG);
    row_lo = {cur_k[0], f_eff};
    cur_line = line_pos(cur_k, f_eff);
    gidx = ifd_pkg::GI_MONO;
    if (cur_mode == ifd_pkg::IFD_MODE_FIELD) begin
      // pair type flips every two rows from the bottom
      gidx = {row_lo[1] ^ row_lo[0], cur_col[0]};
    end else if (cur_mode == ifd_pkg::IFD_MODE_FRAME) begin
      if (row_lo[0]) begin
        gidx = cur_col[0] ? ifd_pkg::GI_YE : ifd_pkg::GI_CY;
      end else begin
        gidx = (cur_col[0] ^ row_lo[1]) ? ifd_pkg::GI_MG : ifd_pkg::GI_G;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_k <= '0;
      col <= '0;
      field <= 1'b0;
      active_mode <= ifd_pkg::IFD_MODE_FIELD;
    end else if (acc) begin
      line_k <= cur_k;
      col <= cur_col;
      field <= cur_field;
      active_mode <= cur_mode;
    end
  end

  // ----------------------------------------------------------------
  // gain and first-field store
  // ----------------------------------------------------------------
  logic [ifd_pkg::OUT_W-1:0] g;
  logic [ifd_pkg::OUT_W-1:0] fmem [ifd_pkg::MEM_DEPTH];
  logic [ifd_pkg::FL_AW+ifd_pkg::COL_W-1:0] mem_idx;
  logic [ifd_pkg::SUM_W-1:0] cv;

  ifd_gain u_gain (
    .pix(in_data),
    .gain(gain[gidx]),
    .result(g)
  );

  assign mem_idx = {cur_k[ifd_pkg::FL_AW-1:0], cur_col};

  // only a few lines fit; the host must keep the frame mode window small
  always_ff @(posedge clk) begin
    if (acc && cur_mode == ifd_pkg::IFD_MODE_FRAME && !cur_field) begin
      fmem[mem_idx] <= g;
    end
  end

  always_comb begin
    // second frame field: add the stored line above to deinterlace
    if (cur_mode == ifd_pkg::IFD_MODE_FRAME && cur_field) begin
      cv = {1'b0, g} + {1'b0, fmem[mem_idx]};
    end else begin
      cv = {1'b0, g};
    end
  end

  // ----------------------------------------------------------------
  // pixel pair sequencer
  // ----------------------------------------------------------------
  logic [ifd_pkg::OUT_W-1:0] g0;
  logic [ifd_pkg::SUM_W-1:0] cv0;
  logic [2+ifd_pkg::LINE_W:0] meta0;
  logic [ifd_pkg::WORD_W-1:0] held;
  logic buf_push;
  logic [ifd_pkg::WORD_W-1:0] buf_word;
  logic [ifd_pkg::WORD_W-1:0] next_held;
  ifd_pkg::ifd_state_t next_state;
  logic [ifd_pkg::SUM_W:0] ysum;
  logic [ifd_pkg::AUX_W-1:0] luma;
  logic [ifd_pkg::AUX_W-1:0] chroma;
  logic [ifd_pkg::SUM_W-1:0] hbin;
  logic [ifd_pkg::OUT_W-1:0] hbin_sat;
  logic [2+ifd_pkg::LINE_W:0] meta1;

  always_comb begin
    ysum = {1'b0, cv0} + {1'b0, cv};
    luma = {1'b0, ysum[ifd_pkg::SUM_W:1]};
    // odd column minus even column yields R-Y or -(B-Y) by pair type
    chroma = {1'b0, cv} - {1'b0, cv0};
    hbin = {1'b0, g0} + {1'b0, g};
    hbin_sat = hbin[ifd_pkg::OUT_W] ? '1 : hbin[ifd_pkg::OUT_W-1:0];
    meta1 = {2'b00, meta0[ifd_pkg::LINE_W:0]};
    buf_push = 1'b0;
    buf_word = held;
    next_held = held;
    next_state = state;
    case (state)
      ifd_pkg::ST_P0: begin
        if (acc) begin
          next_state = ifd_pkg::ST_P1;
        end
      end
      ifd_pkg::ST_P1: begin
        if (acc) begin
          buf_push = 1'b1;
          if (active_mode == ifd_pkg::IFD_MODE_PROG) begin
            // one mono word per pair, never a colour component
            buf_word = {meta0, hbin_sat, {ifd_pkg::AUX_W{1'b0}}};
            next_state = ifd_pkg::ST_P0;
          end else if (active_mode == ifd_pkg::IFD_MODE_FRAME && !meta0[ifd_pkg::LINE_W]) begin
            buf_word = {meta0, g0, {ifd_pkg::AUX_W{1'b0}}};
            next_held = {meta1, g, {ifd_pkg::AUX_W{1'b0}}};
            next_state = ifd_pkg::ST_EMIT2;
          end else begin
            buf_word = {meta0, g0, luma};
            next_held = {meta1, g, chroma};
            next_state = ifd_pkg::ST_EMIT2;
          end
        end
      end
      ifd_pkg::ST_EMIT2: begin
        if (buf_ready) begin
          buf_push = 1'b1;
          next_state = ifd_pkg::ST_P0;
        end
      end
      default: begin
        next_state = ifd_pkg::ST_P0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ifd_pkg::ST_P0;
      held <= '0;
    end else begin
      state <= next_state;
      held <= next_held;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      g0 <= '0;
      cv0 <= '0;
      meta0 <= '0;
    end else if (acc && state == ifd_pkg::ST_P0) begin
      g0 <= g;
      cv0 <= cv;
      meta0 <= {in_sof, in_sof || in_sol, cur_field, cur_line};
    end
  end

  // ----------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------
  ifd_skid #(
    .W(ifd_pkg::WORD_W)
  ) u_skid (
    .clk(clk),
    .resetn(resetn),
    .in_valid(buf_push),
    .in_ready(buf_ready),
    .in_data(buf_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_sof, out_sol, out_field, out_line, out_pix, out_aux})
  );

  // ----------------------------------------------------------------
  // integration window and shutter pulse
  // ----------------------------------------------------------------
  logic [ifd_pkg::SHUT_W-1:0] int_cnt;
  logic [ifd_pkg::SHUT_W-1:0] next_int_cnt;

  assign next_int_cnt = int_cnt + {{(ifd_pkg::SHUT_W-1){1'b0}}, 1'b1};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      integration_active_out <= 1'b0;
      shutter_dump_out <= 1'b0;
      int_cnt <= '0;
    end else begin
      shutter_dump_out <= 1'b0;
      if (acc && in_sof && (cur_mode != ifd_pkg::IFD_MODE_FRAME || !in_field)) begin
        // frame mode opens once per frame so the window covers both fields
        integration_active_out <= 1'b1;
        int_cnt <= '0;
        // overlapping fields leave no room for a charge dump in frame mode
        shutter_dump_out <= (cur_mode != ifd_pkg::IFD_MODE_FRAME);
      end else if (acc && in_sol && integration_active_out) begin
        int_cnt <= next_int_cnt;
        if (next_int_cnt >= shutter) begin
          integration_active_out <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        if (reg_addr == ifd_pkg::REG_CTRL) begin
          reg_rdata[1:0] <= mode_req;
          reg_rdata[ifd_pkg::CTRL_ACT_LSB +: 2] <= active_mode;
          reg_rdata[ifd_pkg::CTRL_COLOR_BIT] <= color_camera;
        end else if (reg_addr == ifd_pkg::REG_SHUTTER) begin
          reg_rdata[ifd_pkg::SHUT_W-1:0] <= shutter;
        end else if (reg_addr == ifd_pkg::REG_STATUS) begin
          reg_rdata[0] <= field;
          reg_rdata[1] <= integration_active_out;
          reg_rdata[ifd_pkg::STAT_LINE_LSB +: ifd_pkg::LINE_W] <= line_k;
        end else begin
          for (int i = 0; i < ifd_pkg::NUM_GAINS; i++) begin
            if (is_gain_addr(reg_addr, i)) begin
              reg_rdata[ifd_pkg::GAIN_W-1:0] <= gain[i];
            end
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> verif/ifd_readout_monitor.sv
// assertion checker for the interlaced field readout block
`timescale 1ns/1ps
`default_nettype none
module ifd_readout_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [ifd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ifd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ifd_pkg::DATA_W-1:0] reg_rdata,
  input wire logic color_camera_pin,
  // streams and timing
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic in_sof,
  input wire logic in_field,
  input wire logic out_valid,
  input wire logic [ifd_pkg::AUX_W-1:0] out_aux,
  input wire logic [ifd_pkg::LINE_W-1:0] out_line,
  input wire logic out_field,
  input wire logic integration_active_out,
  input wire logic shutter_dump_out
);
  logic [1:0] req;
  logic [1:0] act;
  logic s1;
  logic s2;
  logic sof_ok;
  assign sof_ok = in_valid && in_ready && in_sof;
  // ------------------------------------------------
  // shadow of requested and active mode
  // ------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      req <= 2'h0;
      act <= 2'h0;
    end else begin
      s1 <= color_camera_pin;
      s2 <= s1;
      // colour strap refuses progressive mode
      if (reg_wr && reg_addr == ifd_pkg::REG_CTRL && reg_wdata[1:0] != 2'h3 &&
          !(reg_wdata[1:0] == 2'h2 && s2)) begin
        req <= reg_wdata[1:0];
      end
      if (sof_ok && !in_field) begin
        act <= req;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_field_start;
    sof_ok && (!in_field || act != ifd_pkg::IFD_MODE_FRAME);
  endsequence
  sequence s_ctrl_read;
    reg_rd && reg_addr == ifd_pkg::REG_CTRL;
  endsequence
  property p_first_odd;
    out_valid && !out_field |-> out_line[0];
  endproperty
  property p_second_even;
    out_valid && out_field && act != ifd_pkg::IFD_MODE_PROG |-> !out_line[0];
  endproperty
  property p_prog_odd;
    out_valid && act == ifd_pkg::IFD_MODE_PROG |-> out_line[0];
  endproperty
  property p_no_dump;
    act == ifd_pkg::IFD_MODE_FRAME |-> !shutter_dump_out;
  endproperty
  property p_no_colour;
    out_valid && act == ifd_pkg::IFD_MODE_PROG |-> out_aux == '0;
  endproperty
  property p_int_rise;
    s_field_start |-> ##[1:2] integration_active_out;
  endproperty
  property p_ctrl_rd;
    s_ctrl_read |=> reg_rdata[5:4] == $past(act) && reg_rdata[1:0] == $past(req);
  endproperty
  property p_shut_min;
    reg_rd && reg_addr == ifd_pkg::REG_SHUTTER && req == ifd_pkg::IFD_MODE_FRAME
      |=> reg_rdata[15:0] >= ifd_pkg::MIN_FRAME_SHUTTER;
  endproperty
  a_first_odd: assert property (p_first_odd) else $error("first field line not odd");
  a_second_even: assert property (p_second_even) else $error("second field line odd");
  a_prog_odd: assert property (p_prog_odd) else $error("binned line not odd");
  a_no_dump: assert property (p_no_dump) else $error("shutter pulse in frame mode");
  a_no_colour: assert property (p_no_colour) else $error("colour in mono mode");
  a_int_rise: assert property (p_int_rise) else $error("integration not raised");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("mode readback wrong");
  a_shut_min: assert property (p_shut_min) else $error("frame shutter too short");
endmodule
bind ifd_readout ifd_readout_monitor u_mon (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .color_camera_pin(color_camera_pin), .in_valid(in_valid),
  .in_ready(in_ready), .in_sof(in_sof), .in_field(in_field), .out_valid(out_valid),
  .out_aux(out_aux), .out_line(out_line), .out_field(out_field),
  .integration_active_out(integration_active_out), .shutter_dump_out(shutter_dump_out));
`default_nettype wire

// >>> verif/ifd_partner.sv
// front-end pixel source and host-link sink for the readout bench
`timescale 1ns/1ps
`default_nettype none
module ifd_partner (
  // clock
  input wire logic clk,
  // pixel stream into the block
  output logic in_valid,
  input wire logic in_ready,
  output logic [ifd_pkg::PIX_W-1:0] in_data,
  output logic in_sof,
  output logic in_sol,
  output logic in_field,
  // host side
  input wire logic stall,
  output logic out_ready
);
  int hangs;
  logic [3:0] cnt;
  initial begin
    in_valid = 1'b0;
    in_data = 10'h155;
    in_sof = 1'b0;
    in_sol = 1'b0;
    in_field = 1'b0;
    hangs = 0;
    cnt = 4'h0;
    out_ready = 1'b1;
  end
  // a host taking one word in four fills the buffer
  always @(posedge clk) begin
    cnt <= cnt + 4'h1;
    out_ready <= !stall || cnt[1:0] == 2'h3;
  end
  function automatic logic [ifd_pkg::PIX_W-1:0] pv(int k, int c);
    return 10'(32'h20 + 32'h10 * k + 32'h5 * c);
  endfunction
  task automatic send_field(input logic f, input int lines, input int cols);
    int t;
    for (int k = 0; k < lines; k++) begin
      for (int c = 0; c < cols; c++) begin
        in_valid <= 1'b1;
        in_data <= pv(k, c);
        in_sof <= (k == 0 && c == 0);
        in_sol <= (c == 0);
        in_field <= f;
        t = 0;
        do begin
          @(posedge clk);
          t++;
        end while (!in_ready && t < 100);
        if (!in_ready) hangs++;
      end
    end
    // released data line shows no stale pixel
    in_valid <= 1'b0;
    in_sof <= 1'b0;
    in_data <= ~in_data;
  endtask
endmodule
`default_nettype wire

// >>> verif/ifd_readout_tb.sv
// self-checking bench for the interlaced field readout block
`timescale 1ns/1ps
`default_nettype none
module ifd_readout_tb;
  logic clk, resetn, reg_wr, reg_rd, color_camera_pin, stall;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic in_valid, in_ready, in_sof, in_sol, in_field, out_valid, out_ready;
  logic [9:0] in_data;
  logic [11:0] out_pix, out_line;
  logic [13:0] out_aux;
  logic out_field, out_sof, out_sol, integration_active_out, shutter_dump_out;
  int fails, checked;
  logic [ifd_pkg::WORD_W-1:0] q[$];
  logic [7:0] g [4] = '{8'h40, 8'h80, 8'h20, 8'h10};
  ifd_readout dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .color_camera_pin(color_camera_pin), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_sof(in_sof), .in_sol(in_sol), .in_field(in_field),
    .out_valid(out_valid), .out_ready(out_ready), .out_pix(out_pix), .out_aux(out_aux),
    .out_line(out_line), .out_field(out_field), .out_sof(out_sof), .out_sol(out_sol),
    .integration_active_out(integration_active_out), .shutter_dump_out(shutter_dump_out));
  ifd_partner u_part (.clk(clk), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_sof(in_sof), .in_sol(in_sol), .in_field(in_field),
    .stall(stall), .out_ready(out_ready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (out_valid && out_ready) q.push_back({out_sof, out_sol, out_field, out_line, out_pix, out_aux});
  end
  // ------------------------------------------------
  // shared checks and bus cycles
  // ------------------------------------------------
  task automatic results();
    fails += u_part.hangs;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [40:0] e, input logic [40:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("register", {9'h0, e}, {9'h0, reg_rdata});
    @(posedge clk);
  endtask
  function automatic int gn(int s, int k, int c);
    return (int'(u_part.pv(k, c)) * int'(g[s])) >> 6;
  endfunction
  function automatic int slot(int m, int f, int k, int c);
    int r;
    r = 2 * k + f;
    if (m == 0) return 2 * ((r ^ (r >> 1)) & 1) + (c & 1);
    if (r & 1) return c & 1;
    return ((c ^ k) & 1) ? 2 : 3;
  endfunction
  // one 2x4 field, all words checked
  task automatic t_run(input int m, input logic f, input logic st);
    int n, k, c, t, a, b;
    logic [13:0] ax;
    logic [11:0] px;
    stall <= st;
    q.delete();
    n = (m == 2) ? 4 : 8;
    u_part.send_field(f, 2, 4);
    t = 0;
    while (q.size() < n && t < 500) begin
      @(posedge clk);
      t++;
    end
    repeat (20) @(posedge clk);
    chk("word count", 41'(n), 41'(q.size()));
    if (q.size() < n) results();
    for (int i = 0; i < n; i++) begin
      k = (m == 2) ? i / 2 : i / 4;
      c = (m == 2) ? 2 * (i % 2) : i % 4;
      a = gn(slot(m, f, k, c & 2), k, c & 2);
      b = gn(slot(m, f, k, c | 1), k, c | 1);
      px = 12'((c & 1) ? b : a);
      if (m == 1 && f) a += gn(slot(1, 0, k, c & 2), k, c & 2);
      if (m == 1 && f) b += gn(slot(1, 0, k, c | 1), k, c | 1);
      ax = (c & 1) ? 14'(b - a) : 14'((a + b) >> 1);
      if (m == 2) px = 12'(gn(0, k, c) + gn(0, k, c + 1));
      if (m == 2 || (m == 1 && !f)) ax = 14'h0;
      chk("output word", {i == 0, c == 0, f, 12'(2 * k + 1 + ((m == 2) ? 0 : f)), px, ax}, q[i]);
    end
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_regs();
    rd(ifd_pkg::REG_CTRL, 32'h0);
    rd(ifd_pkg::REG_SHUTTER, {16'h0, ifd_pkg::SHUTTER_RESET});
    for (int i = 0; i < 4; i++) rd(ifd_pkg::REG_GAIN0 + 8'(4 * i), {24'h0, ifd_pkg::GAIN_RESET});
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0);
  endtask
  task automatic t_shut();
    wr(ifd_pkg::REG_CTRL, 32'h1);
    rd(ifd_pkg::REG_SHUTTER, 32'h10);
    wr(ifd_pkg::REG_SHUTTER, 32'h8);
    rd(ifd_pkg::REG_SHUTTER, 32'h10);
    wr(ifd_pkg::REG_SHUTTER, 32'h9);
    rd(ifd_pkg::REG_SHUTTER, 32'h9);
    wr(ifd_pkg::REG_CTRL, 32'h0);
    wr(ifd_pkg::REG_SHUTTER, 32'h3);
    rd(ifd_pkg::REG_SHUTTER, 32'h3);
    wr(ifd_pkg::REG_CTRL, 32'h1);
    rd(ifd_pkg::REG_SHUTTER, 32'h9);
  endtask
  task automatic t_field();
    for (int i = 0; i < 4; i++) wr(ifd_pkg::REG_GAIN0 + 8'(4 * i), {24'h0, g[i]});
    wr(ifd_pkg::REG_CTRL, 32'h0);
    t_run(0, 1'b0, 1'b1);
    t_run(0, 1'b1, 1'b1);
  endtask
  task automatic t_frame();
    wr(ifd_pkg::REG_CTRL, 32'h1);
    rd(ifd_pkg::REG_CTRL, 32'h1);
    t_run(1, 1'b0, 1'b0);
    rd(ifd_pkg::REG_CTRL, 32'h11);
    t_run(1, 1'b1, 1'b0);
  endtask
  task automatic t_prog();
    color_camera_pin <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ifd_pkg::REG_CTRL, 32'h2);
    rd(ifd_pkg::REG_CTRL, 32'h111);
    wr(ifd_pkg::REG_CTRL, 32'h3);
    rd(ifd_pkg::REG_CTRL, 32'h111);
    color_camera_pin <= 1'b0;
    repeat (4) @(posedge clk);
    wr(ifd_pkg::REG_CTRL, 32'h2);
    t_run(2, 1'b0, 1'b1);
    t_run(2, 1'b1, 1'b0);
    rd(ifd_pkg::REG_CTRL, 32'h22);
  endtask
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    color_camera_pin = 1'b0;
    stall = 1'b0;
    fails = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_shut();
    t_field();
    t_frame();
    t_prog();
    results();
  end
endmodule
`default_nettype wire
